// File: bench/test_iprc_regs.sv
// Purpose: Self-checking bench for the interrupt priority register bank.
// Assumes: One Wishbone request in flight at a time; ack comes one cycle after the take.
// Notes:   The driver queues each expected answer; a monitor pops it on every ack.
`timescale 1ns/1ps
module test_iprc_regs;
  // One expected answer: read data, field levels and enable flags.
  typedef struct {
    logic        is_rd;
    logic [31:0] dat;
    logic [53:0] prio;
    logic [17:0] en;
  } iprc_note_t;

  // Clock, reset and Wishbone master signals.
  logic             clk_sys_i;
  logic             sys_rst_i;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  wire logic [17:0][2:0] prio_arr;      // Source 0 sits in the low bits.
  logic [17:0]      src_enable_o;
  // Bench state.
  logic [15:0]      model_reg [6];     // Shadow of the six registers.
  iprc_note_t       note_q [$];        // Expected answers, oldest first.
  int               error_cnt;
  int               checked;
  int               cycle_cnt;
  integer           seed;

  iprc_regs iprc_regs_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer4_prio_o(prio_arr[0]), .compare4_prio_o(prio_arr[1]), .compare3_prio_o(prio_arr[2]),
    .uart2_transmit_prio_o(prio_arr[3]), .uart2_receive_prio_o(prio_arr[4]),
    .external_irq2_prio_o(prio_arr[5]), .timer5_prio_o(prio_arr[6]),
    .serial_port2_event_prio_o(prio_arr[7]), .serial_port2_fault_prio_o(prio_arr[8]),
    .capture5_prio_o(prio_arr[9]), .capture4_prio_o(prio_arr[10]),
    .capture3_prio_o(prio_arr[11]), .compare7_prio_o(prio_arr[12]),
    .compare6_prio_o(prio_arr[13]), .compare5_prio_o(prio_arr[14]),
    .capture6_prio_o(prio_arr[15]), .parallel_port_prio_o(prio_arr[16]),
    .compare8_prio_o(prio_arr[17]), .src_enable_o(src_enable_o));

  // Free-running system clock, 100 ns period.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Compares one value; case inequality so an unknown never passes.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Field level of every source as the shadow registers say it should be.
  function automatic logic [53:0] exp_prio();
    logic [53:0] p;
    for (int i = 0; i < iprc_pkg::NUM_SRC; i++)
      p[i*3 +: 3] = model_reg[iprc_pkg::SRC_REG[i]][iprc_pkg::SRC_LSB[i] +: 3];
    return p;
  endfunction

  // Reset pulse of two cycles; the shadow returns to level four in every field.
  task automatic do_reset();
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      model_reg[i] = iprc_pkg::REG_MASK[i] & 16'h4444;
    repeat (2) @(posedge clk_sys_i);
    check(prio_arr, {18{3'h4}});
  endtask

  // One classic cycle; the note is queued before the request goes out.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat);
    int          idx;
    logic [15:0] lanes;
    iprc_note_t  n;
    idx = int'(adr[7:2]);
    if (we && idx < 6)
    begin
      // Lanes 1 and 0 carry the fields; unassigned bits are masked off.
      lanes = {{8{sel[1]}}, {8{sel[0]}}} & iprc_pkg::REG_MASK[idx];
      model_reg[idx] = (model_reg[idx] & ~lanes) | (dat[15:0] & lanes);
    end
    n.is_rd = ~we;
    n.dat   = (idx < 6) ? {16'h0000, model_reg[idx]} : 32'h0000_0000;
    n.prio  = exp_prio();
    for (int i = 0; i < 18; i++)
      n.en[i] = |n.prio[i*3 +: 3];
    note_q.push_back(n);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    @(posedge clk_sys_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_sys_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Reads the six registers and one unmapped word.
  task automatic read_all();
    for (int i = 0; i < 7; i++)
      wb_xfer(1'b0, 8'(i * 4), 4'hF, $random(seed));
  endtask

  // Monitor: every ack retires the oldest note.
  always @(posedge clk_sys_i)
  begin
    iprc_note_t n;
    if (wb_ack_o === 1'b1)
    begin
      if (note_q.size() == 0)
        check(1, 0);
      else
      begin
        n = note_q.pop_front();
        if (n.is_rd)
          check(wb_dat_o, n.dat);
        else
          check(wb_dat_o, 32'h0000_0000);
        check(prio_arr, n.prio);
        check(src_enable_o, n.en);
      end
    end
  end

  // Hang guard at 8000 cycles; every scenario together needs fewer than 700 cycles.
  always @(posedge clk_sys_i)
  begin
    cycle_cnt++;
    if (cycle_cnt == 8000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // Main sequence.
  initial
  begin
    logic [31:0] r;
    error_cnt = 0;
    checked   = 0;
    cycle_cnt = 0;
    seed      = 4;
    sys_rst_i = 1'b1;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h0;
    wb_dat_i  = 32'h0000_0000;
    do_reset();
    read_all();
    // Every code in every field, with the unassigned bits set as well.
    for (int c = 0; c < 8; c++)
    begin
      for (int i = 0; i < 7; i++)
        wb_xfer(1'b1, 8'(i * 4), 4'hF, {16'hFFFF, {4{1'b1, 3'(c)}}});
      read_all();
    end
    // Single lanes and the ignored upper lanes.
    for (int i = 0; i < 6; i++)
    begin
      wb_xfer(1'b1, 8'(i * 4), 4'h2, 32'h0000_2222);
      wb_xfer(1'b1, 8'(i * 4), 4'h1, 32'h0000_5555);
      wb_xfer(1'b1, 8'(i * 4), 4'hC, 32'hFFFF_0000);
    end
    read_all();
    // Random back-to-back traffic, unmapped word included.
    for (int k = 0; k < 60; k++)
    begin
      r = $random(seed);
      wb_xfer(r[31], 8'((r[2:0] % 7) * 4), r[7:4], $random(seed));
    end
    read_all();
    // Reset in mid-run brings every field back to level four.
    do_reset();
    read_all();
    repeat (3) @(posedge clk_sys_i);
    check(note_q.size(), 0);
    complete_run();
  end
endmodule // test_iprc_regs

// File: hdl/iprc_field.sv
// Purpose: One three-bit priority field with its enable flag.
// Assumes: Write strobe and byte lane come from the bus slave on the same clock.
// Notes:   The flag is computed from the next value so both change on the same edge.
`timescale 1ns/1ps
module iprc_field
(
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Write side.
  input  wire logic       wr_en_i,
  input  wire logic       lane_i,
  input  wire logic [2:0] wdat_i,
  // Field state.
  output logic      [2:0] prio_o,
  output logic            enabled_o
);

  logic [2:0] prio_ff;    // Held field value.
  logic       enabled_ff; // High while the source may be taken.
  logic [2:0] nxt_prio;   // Next field value.

  // Only a write that owns this byte lane changes the field.
  always_comb
  begin
    nxt_prio = prio_ff;
    if (wr_en_i && lane_i)
    begin
      nxt_prio = wdat_i;
    end
  end

  // Reset loads level four, which leaves every source enabled at start.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      prio_ff    <= iprc_pkg::PRIO_RESET;
      enabled_ff <= 1'b1;
    end
    else
    begin
      prio_ff    <= nxt_prio;
      enabled_ff <= (nxt_prio != iprc_pkg::PRIO_OFF);
    end
  end

  assign prio_o    = prio_ff;
  assign enabled_o = enabled_ff;

endmodule // iprc_field

// File: hdl/iprc_pkg.sv
// Purpose: Shared constants for the interrupt priority register bank (sources 0 to 17).
// Assumes: Classic Wishbone slave, 32-bit data, one aligned word per register.
// Notes:   Each priority field is three bits wide; a value of zero disables a source.
package iprc_pkg;

  // Bank geometry.
  localparam int NUM_SRC = 18;
  localparam int NUM_REG = 6;
  localparam int FIELD_W = 3;
  localparam int REG_W   = 16;

  // Byte addresses of the six registers.
  localparam logic [7:0] OFF_TIMER4_COMPARE34   = 8'h00;
  localparam logic [7:0] OFF_UART2_EXT2_TIMER5  = 8'h04;
  localparam logic [7:0] OFF_SERIAL_PORT2       = 8'h08;
  localparam logic [7:0] OFF_CAPTURE345         = 8'h0C;
  localparam logic [7:0] OFF_COMPARE567_CAPTURE6 = 8'h10;
  localparam logic [7:0] OFF_PARALLEL_COMPARE8  = 8'h14;

  // Field codes.
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF   = 3'h0;
  localparam logic [2:0] PRIO_MIN   = 3'h1;
  localparam logic [2:0] PRIO_MAX   = 3'h7;

  // Source order: timer4, compare4, compare3, uart2 tx, uart2 rx, external2, timer5,
  // serial2 event, serial2 fault, capture5, capture4, capture3, compare7, compare6,
  // compare5, capture6, parallel port, compare8.
  localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5};
  localparam int SRC_LSB [NUM_SRC] = '{12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0};

  // Implemented bit masks per register, for checking only.
  localparam logic [15:0] REG_MASK [NUM_REG] =
    '{16'h7770, 16'h7777, 16'h0077, 16'h7770, 16'h7777, 16'h0077};

endpackage

// File: hdl/iprc_rd_pack.sv
// Purpose: Assemble the read image of one register from the field values.
// Assumes: Register index has already been decoded and is in range or ignored.
// Notes:   Bits with no field stay zero by construction.
`timescale 1ns/1ps
module iprc_rd_pack
(
  // Field values, source 0 in the low bits.
  input  wire logic [iprc_pkg::NUM_SRC*3-1:0] prio_flat_i,
  // Register selected for reading.
  input  wire logic [2:0]                     reg_idx_i,
  // Register image.
  output logic      [15:0]                    rd_word_o
);

  // Each field lands at its own position; nothing else is ever set.
  always_comb
  begin
    rd_word_o = 16'h0000;
    for (int i = 0; i < iprc_pkg::NUM_SRC; i++)
    begin
      if (iprc_pkg::SRC_REG[i] == int'(reg_idx_i))
      begin
        rd_word_o[iprc_pkg::SRC_LSB[i] +: 3] = prio_flat_i[i*3 +: 3];
      end
    end
  end

endmodule // iprc_rd_pack

// File: hdl/iprc_regs.sv
// Purpose: Priority register bank for eighteen interrupt sources, Wishbone slave.
// Assumes: Classic Wishbone cycles on clk_sys_i; one register per aligned word.
// Notes:   Answers every access one cycle after the request, mapped or not.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module iprc_regs
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Priority levels towards the arbiter.
  output logic      [2:0]  timer4_prio_o,
  output logic      [2:0]  compare4_prio_o,
  output logic      [2:0]  compare3_prio_o,
  output logic      [2:0]  uart2_transmit_prio_o,
  output logic      [2:0]  uart2_receive_prio_o,
  output logic      [2:0]  external_irq2_prio_o,
  output logic      [2:0]  timer5_prio_o,
  output logic      [2:0]  serial_port2_event_prio_o,
  output logic      [2:0]  serial_port2_fault_prio_o,
  output logic      [2:0]  capture5_prio_o,
  output logic      [2:0]  capture4_prio_o,
  output logic      [2:0]  capture3_prio_o,
  output logic      [2:0]  compare7_prio_o,
  output logic      [2:0]  compare6_prio_o,
  output logic      [2:0]  compare5_prio_o,
  output logic      [2:0]  capture6_prio_o,
  output logic      [2:0]  parallel_port_prio_o,
  output logic      [2:0]  compare8_prio_o,
  // Per-source enable, high when the field is non-zero.
  output logic      [17:0] src_enable_o
);

  // In short: a request is taken at the edge where cyc and stb are high and ack is low.
  // That edge loads the field and the read image, and ack stands for the next cycle only.
  // The master must drop cyc and stb once it has seen ack, and may raise them again in
  // the cycle after the drop. There are no wait states and no error answer.

  logic        ack_ff;                          // Bus answer, one cycle long.
  logic [31:0] dat_ff;                          // Read data held with the answer.
  logic        acc_hit_ff;                      // Answered access hit a register.
  logic [2:0]  acc_idx_ff;                      // Register index of answered access.
  logic        hit;                             // Current address is mapped.
  logic [2:0]  acc_idx;                         // Current register index.
  logic        req;                             // New request, not yet answered.
  logic        wr_stb;                          // Write takes effect this edge.
  logic [15:0] rd_word;                         // Image of addressed register.
  logic [2:0]  prio_w [iprc_pkg::NUM_SRC];      // Field values per source.
  logic [17:0] enable_w;                        // Enable flags per source.
  logic [iprc_pkg::NUM_SRC*3-1:0] prio_flat;    // Field values flattened.

  // Address decode; anything that is not one of the six words is unmapped.
  // Only exact word addresses match, so a stray low address bit cannot alias a
  // register; such an access reads zero and writes nothing.
  always_comb
  begin
    hit     = 1'b1;
    acc_idx = 3'h0;
    if (wb_adr_i == iprc_pkg::OFF_TIMER4_COMPARE34)
    begin
      acc_idx = 3'h0;
    end
    else if (wb_adr_i == iprc_pkg::OFF_UART2_EXT2_TIMER5)
    begin
      acc_idx = 3'h1;
    end
    else if (wb_adr_i == iprc_pkg::OFF_SERIAL_PORT2)
    begin
      acc_idx = 3'h2;
    end
    else if (wb_adr_i == iprc_pkg::OFF_CAPTURE345)
    begin
      acc_idx = 3'h3;
    end
    else if (wb_adr_i == iprc_pkg::OFF_COMPARE567_CAPTURE6)
    begin
      acc_idx = 3'h4;
    end
    else if (wb_adr_i == iprc_pkg::OFF_PARALLEL_COMPARE8)
    begin
      acc_idx = 3'h5;
    end
    else
    begin
      // Unmapped words still get an answer so the master never hangs.
      hit = 1'b0;
    end
  end

  // A request is new while it has not been answered yet.
  // The master still shows its request in the answer cycle, so masking with ack_ff is
  // what keeps one held strobe from being taken, and written, a second time.
  assign req    = wb_cyc_i && wb_stb_i && !ack_ff;
  // Writes to unmapped words are dropped silently.
  assign wr_stb = req && wb_we_i && hit;

  // One field instance per source; the byte lane follows the field position.
  // With only lane 0 set the two upper fields keep their value; lanes 2 and 3 carry
  // no field and are never looked at.
  for (genvar i = 0; i < iprc_pkg::NUM_SRC; i++)
  begin : g_src
    localparam int LSB = iprc_pkg::SRC_LSB[i];
    localparam int RIX = iprc_pkg::SRC_REG[i];
    logic lane;                                 // Byte lane holding this field.
    logic wr_this;                              // Write addressed to our register.
    assign lane    = (LSB >= 8) ? wb_sel_i[1] : wb_sel_i[0];
    assign wr_this = wr_stb && (acc_idx == RIX[2:0]);
    // Each field keeps its own enable flop, so no decode of the code is needed here.
    iprc_field u_field
    (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .wr_en_i   (wr_this),
      .lane_i    (lane),
      .wdat_i    (wb_dat_i[LSB +: 3]),
      .prio_o    (prio_w[i]),
      .enabled_o (enable_w[i])
    );
    assign prio_flat[i*3 +: 3] = prio_w[i];
  end

  // Read image of the addressed register.
  iprc_rd_pack u_rd_pack
  (
    .prio_flat_i (prio_flat),
    .reg_idx_i   (acc_idx),
    .rd_word_o   (rd_word)
  );

  // Answer every request one cycle later and drop the answer the cycle after.
  // The index copy runs free on every edge; it only matters while acc_hit_ff is high,
  // and leaving out an enable term changes nothing in behaviour.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      // No answer is pending while reset is high.
      ack_ff     <= 1'b0;
      acc_hit_ff <= 1'b0;
      acc_idx_ff <= 3'h0;
    end
    else
    begin
      // A held request in the answer cycle sees ack_ff high and is not answered again.
      ack_ff     <= req;
      acc_hit_ff <= req && hit;
      acc_idx_ff <= acc_idx;
    end
  end

  // Read data: the upper half and every unassigned bit read as zero.
  // The image is registered with the answer, so the data on the bus is a copy that
  // stands still for the whole answer cycle.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      dat_ff <= 32'h0000_0000;
    end
    else if (req && !wb_we_i && hit)
    begin
      // Only a mapped read loads the image; writes and unmapped reads answer zero.
      dat_ff <= {16'h0000, rd_word};
    end
    else
    begin
      // Zero outside read answers keeps stale data off the bus.
      dat_ff <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // Field flops drive the arbiter directly, so a write counts from the next cycle.
  // The trade-off: the arbiter sees a new level in the same cycle as the master sees its
  // ack, which is harmless because the level is final at that edge.
  assign timer4_prio_o             = prio_w[0];
  assign compare4_prio_o           = prio_w[1];
  assign compare3_prio_o           = prio_w[2];
  assign uart2_transmit_prio_o     = prio_w[3];
  assign uart2_receive_prio_o      = prio_w[4];
  assign external_irq2_prio_o      = prio_w[5];
  assign timer5_prio_o             = prio_w[6];
  assign serial_port2_event_prio_o = prio_w[7];
  assign serial_port2_fault_prio_o = prio_w[8];
  assign capture5_prio_o           = prio_w[9];
  assign capture4_prio_o           = prio_w[10];
  assign capture3_prio_o           = prio_w[11];
  assign compare7_prio_o           = prio_w[12];
  assign compare6_prio_o           = prio_w[13];
  assign compare5_prio_o           = prio_w[14];
  assign capture6_prio_o           = prio_w[15];
  assign parallel_port_prio_o      = prio_w[16];
  assign compare8_prio_o           = prio_w[17];
  // Level and code are the same number, so 111 is seven and 001 is one.
  assign src_enable_o              = enable_w;

  // Write or read that has just been answered, used by the checks below.
  logic ack_wr;                                 // Answered write to a mapped word.
  logic ack_rd;                                 // Answered read from a mapped word.
  assign ack_wr = wb_ack_o && wb_we_i && acc_hit_ff;
  assign ack_rd = wb_ack_o && !wb_we_i && acc_hit_ff;

  // The checks below sample on the bus clock and, all but chk_reset_value, stand down while reset is high.
  // Answer-cycle checks lean on the master holding its request until it sees ack,
  // which classic cycles require; a master that drops early would trip them falsely.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // A written 111 shows as level seven with the source enabled.
  chk_max_level: assert property (
    ack_wr && acc_idx_ff == 3'h0 && wb_sel_i[1] && wb_dat_i[14:12] == iprc_pkg::PRIO_MAX
    |-> timer4_prio_o == 3'h7 && src_enable_o[0])
    else $error("timer4 field did not take level seven");

  // A written 001 shows as level one with the source still enabled.
  chk_min_level: assert property (
    ack_wr && acc_idx_ff == 3'h5 && wb_sel_i[0] && wb_dat_i[2:0] == iprc_pkg::PRIO_MIN
    |-> compare8_prio_o == 3'h1 && src_enable_o[17])
    else $error("compare8 field did not take level one");

  // A zero compare3 or capture6 field goes with a cleared enable, and the reverse.
  chk_disable_flag: assert property (
    (compare3_prio_o == 3'h0) == !src_enable_o[2]
    && (capture6_prio_o == 3'h0) == !src_enable_o[15])
    else $error("enable flag disagrees with field value");

  // Read answers never show a bit outside a field.
  chk_unused_zero: assert property (
    ack_rd |-> wb_dat_o[31:16] == 16'h0000
    && (wb_dat_o[15:0] & ~iprc_pkg::REG_MASK[acc_idx_ff]) == 16'h0000)
    else $error("unimplemented bit read as one");

  // The first cycle after reset shows level four in timer4 and compare8, with every enable set.
  chk_reset_value: assert property (
    disable iff (1'b0)
    $past(sys_rst_i) && !sys_rst_i
    |-> timer4_prio_o == 3'h4 && compare8_prio_o == 3'h4 && src_enable_o == 18'h3FFFF)
    else $error("field not at level four after reset");

  // Without a write to its register a field holds its value.
  chk_field_holds: assert property (
    !(wr_stb && acc_idx == 3'h5) |=> $stable(parallel_port_prio_o))
    else $error("parallel port field changed without a write");

  // Register 0 read shows timer4, compare4 and compare3 at their places.
  chk_reg0_layout: assert property (
    ack_rd && acc_idx_ff == 3'h0
    |-> wb_dat_o[14:12] == timer4_prio_o && wb_dat_o[10:8] == compare4_prio_o
    && wb_dat_o[6:4] == compare3_prio_o && wb_dat_o[3:0] == 4'h0)
    else $error("register 0 layout wrong");

  // Register 1 read shows all four fields.
  chk_reg1_layout: assert property (
    ack_rd && acc_idx_ff == 3'h1
    |-> wb_dat_o[14:12] == uart2_transmit_prio_o && wb_dat_o[10:8] == uart2_receive_prio_o
    && wb_dat_o[6:4] == external_irq2_prio_o && wb_dat_o[2:0] == timer5_prio_o)
    else $error("register 1 layout wrong");

  // Register 2 read has an empty upper part.
  chk_reg2_layout: assert property (
    ack_rd && acc_idx_ff == 3'h2
    |-> wb_dat_o[15:7] == 9'h000 && wb_dat_o[6:4] == serial_port2_event_prio_o
    && wb_dat_o[2:0] == serial_port2_fault_prio_o)
    else $error("register 2 layout wrong");

  // Register 3 read shows the three capture fields.
  chk_reg3_layout: assert property (
    ack_rd && acc_idx_ff == 3'h3
    |-> wb_dat_o[14:12] == capture5_prio_o && wb_dat_o[10:8] == capture4_prio_o
    && wb_dat_o[6:4] == capture3_prio_o)
    else $error("register 3 layout wrong");

  // Register 4 read shows three compare fields and capture6.
  chk_reg4_layout: assert property (
    ack_rd && acc_idx_ff == 3'h4
    |-> wb_dat_o[14:12] == compare7_prio_o && wb_dat_o[10:8] == compare6_prio_o
    && wb_dat_o[6:4] == compare5_prio_o && wb_dat_o[2:0] == capture6_prio_o)
    else $error("register 4 layout wrong");

  // Register 5 read shows parallel port and compare8.
  chk_reg5_layout: assert property (
    ack_rd && acc_idx_ff == 3'h5
    |-> wb_dat_o[15:7] == 9'h000 && wb_dat_o[6:4] == parallel_port_prio_o
    && wb_dat_o[2:0] == compare8_prio_o)
    else $error("register 5 layout wrong");

  // A write is visible at the arbiter outputs by the cycle the answer shows.
  chk_write_effect: assert property (
    wr_stb && acc_idx == 3'h3 && wb_sel_i[1]
    |=> capture5_prio_o == $past(wb_dat_i[14:12]) && wb_ack_o)
    else $error("capture5 field not updated one cycle after write");

  // Every request is answered exactly one cycle later, then the answer drops.
  chk_ack_timing: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");

  // Code 000 written to the serial port2 fault field clears its enable in the answer cycle.
  chk_off_code: assert property (
    ack_wr && acc_idx_ff == 3'h2 && wb_sel_i[0] && wb_dat_i[2:0] == iprc_pkg::PRIO_OFF
    |-> serial_port2_fault_prio_o == 3'h0 && !src_enable_o[8])
    else $error("serial port2 fault field not disabled by code zero");

  // A write without lane 1 must leave the timer4 field alone.
  chk_lane_guard: assert property (
    wr_stb && acc_idx == 3'h0 && !wb_sel_i[1] |=> $stable(timer4_prio_o))
    else $error("timer4 field changed without its byte lane");

  // A write that carries only the upper lanes changes no field at all.
  chk_upper_lanes: assert property (
    wr_stb && wb_sel_i[1:0] == 2'b00 |=> $stable(prio_flat) && $stable(enable_w))
    else $error("upper byte lanes changed a field");

  // A write to an unmapped word is answered but changes no field.
  chk_unmapped_write: assert property (
    req && wb_we_i && !hit |=> $stable(prio_flat) && $stable(enable_w))
    else $error("unmapped write changed a field");

  // An answer from an unmapped word carries zero data.
  chk_unmapped_zero: assert property (
    wb_ack_o && !acc_hit_ff |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped answer carried data");

  // Outside an answer the read data lines stay at zero.
  chk_idle_data: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data shown without an answer");

  // Main scenarios.
  cov_write_max:  cover property (ack_wr && wb_dat_i[14:12] == iprc_pkg::PRIO_MAX);
  cov_disable:    cover property ($fell(src_enable_o[0]));
  cov_read_reg5:  cover property (ack_rd && acc_idx_ff == 3'h5);
  cov_unmapped:   cover property (wb_ack_o && !acc_hit_ff);
  cov_write_off:  cover property (ack_wr && !src_enable_o[8]);

endmodule // iprc_regs
